// *** dcc_regs.svh ***
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define CMD_FILL        8'h14
`define CMD_BLOCK_PROG  8'h15
`define CMD_CALIBRATE   8'h60
`define CMD_OFS_X       8'h61
`define CMD_OFS_Y       8'h62
`define CMD_OFS_Z       8'h63
`define DISP_COLS       76
`define DISP_BYTES      152
`define DISP_AW         8
`define BLOCK_BYTES     4'h8
`define BLOCK_SHIFT     3
`define CAL_LIMIT       3'h7
`define CAL_CNT_ERASED  3'h0
`define NUM_AXES        3
`endif

// *** dcc_pkg.sv ***
package dcc_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ARG  = 5'h02,
        ST_FILL = 5'h04,
        ST_PROG = 5'h08,
        ST_CAL  = 5'h10
    } dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'h1,
        H_SEND = 3'h2,
        H_WAIT = 3'h4
    } host_state_t;
endpackage

// *** dcc_if.sv ***
`timescale 1ns/1ps
interface dcc_if;
    logic       byte_vld;
    logic [7:0] byte_dat;
    logic       frame_start;
    logic       busy;
    modport device (input byte_vld, input byte_dat, input frame_start, output busy);
    modport host   (output byte_vld, output byte_dat, output frame_start, input busy);
endinterface

// *** dcc_host.sv ***
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_host (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [71:0] args_i,
    input  wire logic [3:0]  nargs_i,
    output logic             done_o,
    dcc_if.host              link
);
    typedef struct packed {
        dcc_pkg::host_state_t st;
        logic [79:0]          sh;
        logic [3:0]           left;
        logic                 vld;
        logic                 start;
        logic                 done;
        logic [7:0]           dat;
    } host_t;
    host_t s_ff;
    host_t nxt_s;

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.vld   = 1'b0;
        nxt_s.start = 1'b0;
        nxt_s.done  = 1'b0;
        case (s_ff.st)
            dcc_pkg::H_IDLE: begin
                if (req_i) begin
                    nxt_s.sh    = {cmd_i, args_i};
                    nxt_s.left  = nargs_i + 4'h1;
                    nxt_s.start = 1'b1;
                    nxt_s.st    = dcc_pkg::H_SEND;
                end
            end
            dcc_pkg::H_SEND: begin
                if (s_ff.left == 4'h0) begin
                    nxt_s.st = dcc_pkg::H_WAIT;
                end else if (!link.busy && !s_ff.vld) begin
                    nxt_s.vld  = 1'b1;
                    nxt_s.dat  = s_ff.sh[79:72];
                    nxt_s.sh   = {s_ff.sh[71:0], 8'h00};
                    nxt_s.left = s_ff.left - 4'h1;
                end
            end
            dcc_pkg::H_WAIT: begin
                if (!link.busy && !s_ff.vld) begin
                    nxt_s.done = 1'b1;
                    nxt_s.st   = dcc_pkg::H_IDLE;
                end
            end
            default: nxt_s.st = dcc_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '{st: dcc_pkg::H_IDLE, sh: 80'h0, left: 4'h0,
                      vld: 1'b0, start: 1'b0, done: 1'b0, dat: 8'h00};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.byte_vld    = s_ff.vld;
    assign link.byte_dat    = s_ff.dat;
    assign link.frame_start = s_ff.start;
    assign done_o           = s_ff.done;
endmodule

// *** dcc_device.sv ***
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_device (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    dcc_if.device            link,
    input  wire logic [15:0] zero_g_x_i,
    input  wire logic [15:0] zero_g_y_i,
    input  wire logic [15:0] zero_g_z_i,
    input  wire logic [6:0]  col_sel_i,
    output logic [15:0]      col_word_o,
    output logic [15:0]      cal_x_o,
    output logic [15:0]      cal_y_o,
    output logic [15:0]      cal_z_o,
    output logic [2:0]       cal_full_o
);
    typedef struct packed {
        dcc_pkg::dev_state_t st;
        logic [7:0]          cmd;
        logic [3:0]          cnt;
        logic [7:0]          base;
        logic                skip;
        logic [7:0]          fill_adr;
        logic [7:0]          fill_val;
        logic [2:0][7:0]     ofs;
        logic                busy;
        logic [15:0]         col;
        logic [2:0][15:0]    cal_out;
        logic [2:0]          full;
    } dev_t;
    dev_t s_ff;
    dev_t nxt_s;

    // Nonvolatile store: no reset, so calibration survives reset and upgrade
    logic [7:0]       ram [0:`DISP_BYTES-1];
    logic [15:0]      nv_cal [0:`NUM_AXES-1];
    logic [2:0]       nv_cnt [0:`NUM_AXES-1] = '{default: `CAL_CNT_ERASED};
    wire  [2:0]       nv_room;
    wire  [15:0]      ofs_ext [0:`NUM_AXES-1];
    logic [2:0][15:0] zg;
    logic             wr_en;
    logic [7:0]       wr_adr;
    logic [7:0]       wr_dat;
    logic             cal_go;

    assign zg = {zero_g_z_i, zero_g_y_i, zero_g_x_i};

    always_comb begin
        nxt_s  = s_ff;
        wr_en  = 1'b0;
        wr_adr = 8'h00;
        wr_dat = 8'h00;
        cal_go = 1'b0;

        // Command state machine
        case (s_ff.st)
            dcc_pkg::ST_IDLE: begin
                if (link.byte_vld) begin
                    nxt_s.cmd = link.byte_dat;
                    nxt_s.cnt = 4'h0;
                    case (link.byte_dat)
                        `CMD_CALIBRATE: begin
                            nxt_s.st   = dcc_pkg::ST_CAL;
                            nxt_s.busy = 1'b1;
                        end
                        `CMD_FILL: begin
                            nxt_s.st = dcc_pkg::ST_ARG;
                        end
                        `CMD_BLOCK_PROG: begin
                            nxt_s.st = dcc_pkg::ST_ARG;
                        end
                        `CMD_OFS_X: begin
                            nxt_s.st = dcc_pkg::ST_ARG;
                        end
                        `CMD_OFS_Y: begin
                            nxt_s.st = dcc_pkg::ST_ARG;
                        end
                        `CMD_OFS_Z: begin
                            nxt_s.st = dcc_pkg::ST_ARG;
                        end
                        default: nxt_s.st = dcc_pkg::ST_IDLE;
                    endcase
                end
            end

            dcc_pkg::ST_ARG: begin
                if (link.frame_start) begin
                    nxt_s.st = dcc_pkg::ST_IDLE;
                end else if (link.byte_vld) begin
                    case (s_ff.cmd)
                        `CMD_FILL: begin
                            nxt_s.fill_val = link.byte_dat;
                            nxt_s.fill_adr = 8'h00;
                            nxt_s.busy     = 1'b1;
                            nxt_s.st       = dcc_pkg::ST_FILL;
                        end

                        `CMD_BLOCK_PROG: begin
                            nxt_s.base = {link.byte_dat[4:0], 3'h0};
                            nxt_s.skip = (link.byte_dat >
                                          8'((`DISP_BYTES >> `BLOCK_SHIFT) - 1));
                            nxt_s.cnt  = 4'h0;
                            nxt_s.st   = dcc_pkg::ST_PROG;
                        end

                        `CMD_OFS_X: begin
                            nxt_s.ofs[0] = link.byte_dat;
                            nxt_s.st     = dcc_pkg::ST_IDLE;
                        end

                        `CMD_OFS_Y: begin
                            nxt_s.ofs[1] = link.byte_dat;
                            nxt_s.st     = dcc_pkg::ST_IDLE;
                        end

                        `CMD_OFS_Z: begin
                            nxt_s.ofs[2] = link.byte_dat;
                            nxt_s.st     = dcc_pkg::ST_IDLE;
                        end

                        default: nxt_s.st = dcc_pkg::ST_IDLE;
                    endcase
                end
            end

            dcc_pkg::ST_FILL: begin
                wr_en  = 1'b1;
                wr_adr = s_ff.fill_adr;
                wr_dat = s_ff.fill_val;
                nxt_s.fill_adr = s_ff.fill_adr + 8'h01;
                if (s_ff.fill_adr == 8'(`DISP_BYTES - 1)) begin
                    nxt_s.busy = 1'b0;
                    nxt_s.st   = dcc_pkg::ST_IDLE;
                end
            end

            dcc_pkg::ST_PROG: begin
                if (link.frame_start) begin
                    nxt_s.st = dcc_pkg::ST_IDLE;
                end else if (link.byte_vld) begin
                    wr_en  = !s_ff.skip;
                    wr_adr = s_ff.base + {4'h0, s_ff.cnt};
                    wr_dat = link.byte_dat;
                    nxt_s.cnt = s_ff.cnt + 4'h1;
                    if (s_ff.cnt == `BLOCK_BYTES - 4'h1) begin
                        nxt_s.st = dcc_pkg::ST_IDLE;
                    end
                end
            end

            dcc_pkg::ST_CAL: begin
                cal_go     = 1'b1;
                nxt_s.busy = 1'b0;
                nxt_s.st   = dcc_pkg::ST_IDLE;
            end

            default: nxt_s.st = dcc_pkg::ST_IDLE;
        endcase

        nxt_s.col = {ram[{col_sel_i, 1'b1}], ram[{col_sel_i, 1'b0}]};
        for (int a = 0; a < `NUM_AXES; a++) begin
            nxt_s.cal_out[a] = nv_cal[a] + ofs_ext[a];
            nxt_s.full[a]    = !nv_room[a];
        end
    end

    // Display RAM write port
    always_ff @(posedge core_clk_i) begin
        if (wr_en && wr_adr < 8'(`DISP_BYTES)) begin
            ram[wr_adr] <= wr_dat;
        end
    end

    // Calibration store per axis
    genvar g;
    generate
        for (g = 0; g < `NUM_AXES; g++) begin : g_axis
            assign nv_room[g] = (nv_cnt[g] != `CAL_LIMIT);
            assign ofs_ext[g] = {{8{s_ff.ofs[g][7]}}, s_ff.ofs[g]};
            always_ff @(posedge core_clk_i) begin
                if (cal_go && nv_room[g]) begin
                    nv_cal[g] <= zg[g];
                    nv_cnt[g] <= nv_cnt[g] + 3'h1;
                end
            end
        end
    endgenerate

    // State register, reset clears offsets
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '{st: dcc_pkg::ST_IDLE, cmd: 8'h00, cnt: 4'h0, base: 8'h00,
                      skip: 1'b0, fill_adr: 8'h00, fill_val: 8'h00,
                      ofs: 24'h0, busy: 1'b0, col: 16'h0000,
                      cal_out: 48'h0, full: 3'h0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Registered outputs
    assign link.busy  = s_ff.busy;
    assign col_word_o = s_ff.col;
    assign cal_x_o    = s_ff.cal_out[0];
    assign cal_y_o    = s_ff.cal_out[1];
    assign cal_z_o    = s_ff.cal_out[2];
    assign cal_full_o = s_ff.full;
endmodule

// *** dcc_monitor.sv ***
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_monitor (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       byte_vld,
    input  wire logic [7:0] byte_dat,
    input  wire logic       frame_start,
    input  wire logic       busy
);
    logic [7:0] busy_cnt_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) busy_cnt_ff <= 8'h00;
        else busy_cnt_ff <= busy ? busy_cnt_ff + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence opc_s(logic [7:0] op);
        frame_start ##1 (byte_vld && byte_dat == op);
    endsequence
    AST_VLD_PULSE: assert property (byte_vld |=> !byte_vld)
        else $error("byte strobe longer than one cycle");
    AST_FRAME_PULSE: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    AST_OPC_AFTER_FRAME: assert property (frame_start |=> byte_vld)
        else $error("opcode not one cycle after frame start");
    AST_DAT_HELD: assert property (byte_vld |=> $stable(byte_dat))
        else $error("byte data changed after strobe");
    AST_NO_BYTE_BUSY: assert property (busy |-> !byte_vld)
        else $error("byte offered while busy");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_ff inside {8'h01, 8'h98})
        else $error("busy length wrong");
    AST_FILL_BUSY: assert property (opc_s(`CMD_FILL) ##2 byte_vld |-> ##[0:3] busy)
        else $error("fill did not raise busy");
    AST_CAL_BUSY: assert property (opc_s(`CMD_CALIBRATE) |-> ##[0:3] busy)
        else $error("calibrate did not raise busy");
    COV_FILL: cover property (opc_s(`CMD_FILL));
    COV_PROG: cover property (opc_s(`CMD_BLOCK_PROG));
    COV_CAL: cover property (opc_s(`CMD_CALIBRATE));
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        core_clk_i;
    logic        rst_i;
    logic        req;
    logic        done;
    logic [7:0]  cmd;
    logic [71:0] args;
    logic [3:0]  nargs;
    logic [15:0] zx, zy, zz, col_word, cx, cy, cz;
    logic [6:0]  col_sel;
    logic [2:0]  full;
    int          fail_count = 0;
    int          tests_run = 0;
    dcc_if dcc_if_i ();
    dcc_host dcc_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .cmd_i(cmd),
        .args_i(args), .nargs_i(nargs), .done_o(done), .link(dcc_if_i));
    dcc_device dcc_device_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(dcc_if_i),
        .zero_g_x_i(zx), .zero_g_y_i(zy), .zero_g_z_i(zz), .col_sel_i(col_sel),
        .col_word_o(col_word), .cal_x_o(cx), .cal_y_o(cy), .cal_z_o(cz), .cal_full_o(full));
    dcc_monitor dcc_monitor_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .byte_vld(dcc_if_i.byte_vld), .byte_dat(dcc_if_i.byte_dat),
        .frame_start(dcc_if_i.frame_start), .busy(dcc_if_i.busy));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic finish_test();
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [71:0] a, input logic [3:0] n);
        int k;
        cmd = c;
        args = a;
        nargs = n;
        req = 1'b1;
        @(negedge core_clk_i);
        req = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(negedge core_clk_i);
            k++;
        end
        if (k >= 400) fail_count++;
        @(negedge core_clk_i);
    endtask
    task automatic cals(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        chk("cal_x", x, cx);
        chk("cal_y", y, cy);
        chk("cal_z", z, cz);
    endtask
    task automatic col(input logic [6:0] c, input logic [15:0] e);
        col_sel = c;
        @(negedge core_clk_i);
        chk("col_word", e, col_word);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        finish_test();
    end
    initial begin
        rst_i = 1'b1;
        req = 1'b0;
        cmd = 8'h00;
        args = '0;
        nargs = 4'h0;
        col_sel = 7'h00;
        zx = 16'h1234;
        zy = 16'h0800;
        zz = 16'hf010;
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'b0;
        send(8'h60, '0, 4'h0);
        cals(16'h1234, 16'h0800, 16'hf010);
        send(8'h61, {8'hfe, 64'h0}, 4'h1);
        send(8'h62, {8'h05, 64'h0}, 4'h1);
        send(8'h63, {8'h80, 64'h0}, 4'h1);
        cals(16'h1232, 16'h0805, 16'hef90);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        cals(16'h1234, 16'h0800, 16'hf010);
        for (int i = 2; i <= 8; i++) begin
            zx = 16'h1000 + 16'(i);
            zy = 16'h2000 + 16'(i);
            zz = 16'h3000 + 16'(i);
            send(8'h60, '0, 4'h0);
        end
        cals(16'h1007, 16'h2007, 16'h3007);
        chk("cal_full", 16'h0007, {13'h0, full});
        send(8'h14, {8'ha5, 64'h0}, 4'h1);
        col(7'h00, 16'ha5a5);
        col(7'h4b, 16'ha5a5);
        send(8'h15, {8'h12, 64'h0102030405060708}, 4'h9);
        col(7'h48, 16'h0201);
        col(7'h4b, 16'h0807);
        col(7'h47, 16'ha5a5);
        send(8'h15, {8'h13, 64'hffffffffffffffff}, 4'h9);
        col(7'h4b, 16'h0807);
        col(7'h00, 16'ha5a5);
        finish_test();
    end
endmodule
